// ---- hdl/cpps_pkg.sv ----
// Purpose: Shared constants and types for the power and park sequencer
// Assumes: 40 MHz system clock
// Notes: Park times kept in their own units, park cycle counts derived from them; PLL and config counts given in cycles
package cpps_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned NORMAL_PARK_MS = 20;
  localparam int unsigned FAST_PARK_US = 32;
  // Cycle counts are exact products; longest must fit CNT_W bits
  localparam int unsigned NORMAL_PARK_CYC = NORMAL_PARK_MS * 1000 * CLK_MHZ;
  localparam int unsigned FAST_PARK_CYC = FAST_PARK_US * CLK_MHZ;
  localparam int unsigned PLL_LOCK_CYC = 16;
  localparam int unsigned CFG_LOAD_CYC = 64;
  localparam int unsigned CNT_W = 20;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_RESET, ST_PLL_LOCK, ST_CFG_LOAD, ST_OFF, ST_ON, ST_NPARK, ST_FPARK, ST_PARKED
  } cpps_state_e;

  typedef struct packed {
    logic power_on_request;
    logic fast_park_warning_n;
  } cpps_ctrl_s;

  typedef struct packed {
    logic init_status_o;
    logic init_status_oe;
    logic projecting;
    logic parking;
    logic parked;
  } cpps_stat_s;

endpackage

// ---- hdl/cpps_sequencer.sv ----
// Purpose: Power-on, reset release, init status and park sequencing
// Assumes: Inputs from PMIC and host are asynchronous to sys_clk_i
// Notes: Park and init durations stand in for mirror and flash activity
//
// Overview of operation
// - Power-on request high powers up and starts projecting.
// - Power-on request low shuts down to minimal-current state.
// - Auto-initialisation starts on rising edge of system reset.
// - Init status output driven low once auto-initialisation completes.
// - Normal park completes within 20 ms of power-on request falling.
// - Init status output released during system reset; pull-up holds high.
// - Falling park warning starts a fast park.
// - Fast park finishes before the monitor asserts system reset.
// - Init status driven high right after system reset release.
// - Initialisation locks PLL first, then loads flash configuration.
`timescale 1ns/1ps
`default_nettype none

module cpps_sequencer
  import cpps_pkg::*;
#(
  parameter int unsigned NORMAL_PARK_CYCLES = NORMAL_PARK_CYC,
  parameter int unsigned FAST_PARK_CYCLES = FAST_PARK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic system_reset_n_i,
  input wire cpps_pkg::cpps_ctrl_s ctrl_i,
  input wire logic pll_locked_i,
  input wire logic cfg_done_i,
  output cpps_pkg::cpps_stat_s stat_o,
  output logic pll_enable_o,
  output logic cfg_load_o
);
  import cpps_pkg::*;

  if (NORMAL_PARK_CYCLES < 2 || NORMAL_PARK_CYCLES >= (1 << CNT_W)) begin : g_npark_chk
    $error("NORMAL_PARK_CYCLES out of range");
  end
  if (FAST_PARK_CYCLES < 2 || FAST_PARK_CYCLES > NORMAL_PARK_CYCLES) begin : g_fpark_chk
    $error("FAST_PARK_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] NPARK_LAST = CNT_W'(NORMAL_PARK_CYCLES - 1);
  localparam logic [CNT_W-1:0] FPARK_LAST = CNT_W'(FAST_PARK_CYCLES - 1);
  localparam logic [CNT_W-1:0] PLL_LAST = CNT_W'(PLL_LOCK_CYC - 1);
  localparam logic [CNT_W-1:0] CFG_LAST = CNT_W'(CFG_LOAD_CYC - 1);

  // ****************************************
  // Reset release and input synchronisers
  // ****************************************
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_r[1];

  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic sysrst_prev_r;
  logic warn_prev_r;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      sysrst_prev_r <= 1'h0;
      warn_prev_r <= 1'h0;
    end else begin
      meta_r <= {system_reset_n_i, ctrl_i.fast_park_warning_n, ctrl_i.power_on_request};
      sync_r <= meta_r;
      sysrst_prev_r <= sync_r[2];
      warn_prev_r <= sync_r[1];
    end
  end

  logic sysrst_n_s;
  logic warn_n_s;
  logic pon_s;
  logic sysrst_rise;
  logic warn_fall;
  assign sysrst_n_s = sync_r[2];
  assign warn_n_s = sync_r[1];
  assign pon_s = sync_r[0];
  assign sysrst_rise = sysrst_n_s && !sysrst_prev_r;
  assign warn_fall = !warn_n_s && warn_prev_r;

  // ****************************************
  // Sequencer
  // ****************************************
  cpps_state_e state_r;
  cpps_state_e state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic pll_done;
  logic cfg_done;
  assign pll_done = pll_locked_i || (cnt_r == PLL_LAST);
  assign cfg_done = cfg_done_i || (cnt_r == CFG_LAST);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET: begin
        if (sysrst_rise) begin
          state_nxt = ST_PLL_LOCK;
        end
      end
      ST_PLL_LOCK: begin
        if (pll_done) begin
          state_nxt = ST_CFG_LOAD;
        end
      end
      ST_CFG_LOAD: begin
        if (cfg_done) begin
          state_nxt = pon_s ? ST_ON : ST_OFF;
        end
      end
      ST_OFF: begin
        if (pon_s) begin
          state_nxt = ST_ON;
        end
      end
      ST_ON: begin
        if (!pon_s) begin
          state_nxt = ST_NPARK;
        end
      end
      ST_NPARK: begin
        if (cnt_r == NPARK_LAST) begin
          state_nxt = ST_PARKED;
        end
      end
      ST_FPARK: begin
        if (cnt_r == FPARK_LAST) begin
          state_nxt = ST_PARKED;
        end
      end
      ST_PARKED: begin
        if (pon_s && warn_n_s) begin
          state_nxt = ST_ON;
        end
      end
    endcase
    if (warn_fall && state_r != ST_RESET && state_r != ST_FPARK && state_r != ST_PARKED) begin
      state_nxt = ST_FPARK;
    end
    if (!sysrst_n_s) begin
      state_nxt = ST_RESET;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      cnt_r <= '0;
    end else if (state_r inside {ST_PLL_LOCK, ST_CFG_LOAD, ST_NPARK, ST_FPARK}) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stat_o <= '0;
      pll_enable_o <= 1'h0;
      cfg_load_o <= 1'h0;
    end else begin
      stat_o.init_status_oe <= (state_nxt != ST_RESET);
      stat_o.init_status_o <= state_nxt inside {ST_RESET, ST_PLL_LOCK, ST_CFG_LOAD};
      stat_o.projecting <= (state_nxt == ST_ON);
      stat_o.parking <= state_nxt inside {ST_NPARK, ST_FPARK};
      stat_o.parked <= (state_nxt == ST_PARKED);
      pll_enable_o <= (state_nxt != ST_RESET);
      cfg_load_o <= (state_nxt == ST_CFG_LOAD);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  released_in_reset_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    !sysrst_n_s |=> !stat_o.init_status_oe)
    else $error("init status driven during system reset");

  init_start_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (state_r == ST_RESET && sysrst_rise) |=> state_r == ST_PLL_LOCK)
    else $error("init did not start on reset release");

  status_high_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    $rose(state_r == ST_PLL_LOCK) |-> stat_o.init_status_oe && stat_o.init_status_o)
    else $error("init status not high after reset release");

  init_done_low_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (state_r == ST_CFG_LOAD && cfg_done && sysrst_n_s && !warn_fall)
    |=> !stat_o.init_status_o && stat_o.init_status_oe)
    else $error("init status not low after init");

  pll_before_cfg_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    $rose(state_r == ST_CFG_LOAD) |-> $past(state_r) == ST_PLL_LOCK)
    else $error("config load before pll lock");

  power_up_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (state_r == ST_OFF && pon_s && sysrst_n_s && !warn_fall) |=> stat_o.projecting)
    else $error("no power up on request");

  power_down_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (state_r == ST_ON && !pon_s && sysrst_n_s && !warn_fall) |=> state_r == ST_NPARK)
    else $error("no park on request low");

  npark_bound_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    state_r == ST_NPARK |-> cnt_r <= NPARK_LAST)
    else $error("normal park overran");

  fpark_start_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (warn_fall && sysrst_n_s && state_r inside {ST_ON, ST_NPARK}) |=> state_r == ST_FPARK)
    else $error("fast park not started");

  fpark_switch_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (state_r == ST_NPARK && warn_fall && sysrst_n_s) |=> stat_o.parking && state_r == ST_FPARK)
    else $error("normal park not preempted");

  fpark_bound_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    state_r == ST_FPARK |-> cnt_r <= FPARK_LAST)
    else $error("fast park overran");

endmodule

`default_nettype wire

// ---- bench/cpps_pmic_model.sv ----
// Purpose: Power monitor model driving system reset and park warning
// Assumes: Supplies good and fault come from the bench
// Notes: Reset hold shortened to HOLD cycles
`timescale 1ns/1ps
`default_nettype none
module cpps_pmic_model #(
  parameter int HOLD = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic pgood_i,
  input wire logic fault_i,
  input wire logic parked_i,
  output logic sysrst_n_o,
  output logic warn_n_o
);
  int cnt;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 0;
      sysrst_n_o <= 1'b0;
      warn_n_o <= 1'b1;
    end else if (!pgood_i) begin
      cnt <= 0;
      sysrst_n_o <= 1'b0;
      warn_n_o <= 1'b1;
    end else if (fault_i) begin
      warn_n_o <= 1'b0;
      if (parked_i) sysrst_n_o <= 1'b0;
    end else if (cnt < HOLD) begin
      cnt <= cnt + 1;
    end else begin
      sysrst_n_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- bench/cpps_tb_top.sv ----
// Purpose: Self-checking bench for the power and park sequencer
// Assumes: Model stands for the monitor; bench acts as host
// Notes: Park counts shortened by parameter
`timescale 1ns/1ps
`default_nettype none
module controller_power_park_sequencer_tb_top;
  import cpps_pkg::*;
  localparam int NP = 200;
  localparam int FP = 20;
  localparam int PLL = 0, CFG = 1, PRK = 2, PRKG = 3, PRJ = 4, OE = 5, ST = 6;
  logic clk = 0;
  logic rstn = 0;
  logic por = 0;
  logic pgood = 0;
  logic fault = 0;
  logic pll_lk = 0;
  logic cfg_dn = 0;
  logic srst_n;
  logic warn_n;
  wire cpps_ctrl_s ctrl = {por, warn_n};
  cpps_stat_s stat;
  logic pll_en;
  logic cfg_ld;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  initial begin
    forever #12.5 clk = ~clk;
  end
  cpps_sequencer #(.NORMAL_PARK_CYCLES(NP), .FAST_PARK_CYCLES(FP)) i_cpps_sequencer (
    .sys_clk_i(clk), .rstn_i(rstn), .system_reset_n_i(srst_n), .ctrl_i(ctrl),
    .pll_locked_i(pll_lk), .cfg_done_i(cfg_dn), .stat_o(stat),
    .pll_enable_o(pll_en), .cfg_load_o(cfg_ld));
  cpps_pmic_model i_cpps_pmic_model (
    .clk_i(clk), .rstn_i(rstn), .pgood_i(pgood), .fault_i(fault),
    .parked_i(stat.parked), .sysrst_n_o(srst_n), .warn_n_o(warn_n));
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string nm, input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  function automatic logic pick(input int i);
    logic [6:0] v;
    v = {stat, cfg_ld, pll_en};
    return v[i];
  endfunction
  task automatic wt(input string nm, input int i, input logic val, input int lim);
    n = 0;
    while (pick(i) !== val && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(nm, pick(i), val);
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_init();
    @(posedge clk);
    pgood <= 1'b1;
    por <= 1'b1;
    #1;
    wt("pll_en", PLL, 1'b1, 100);
    chk("oe", pick(OE), 1'b1);
    chk("busy", pick(ST), 1'b1);
    wt("cfg_ld", CFG, 1'b1, 30);
    chk("busy_cfg", pick(ST), 1'b1);
    wt("done", ST, 1'b0, 100);
    chk("proj", pick(PRJ), 1'b1);
    $display("test init done");
  endtask
  task automatic t_npark();
    @(posedge clk);
    por <= 1'b0;
    #1;
    wt("parking", PRKG, 1'b1, 10);
    chk("proj_off", pick(PRJ), 1'b0);
    wt("parked", PRK, 1'b1, NP + 10);
    chk("np_len", n >= NP - 5, 1'b1);
    $display("test normal park done");
  endtask
  task automatic t_fpark();
    @(posedge clk);
    por <= 1'b1;
    #1;
    wt("reon", PRJ, 1'b1, 10);
    @(posedge clk);
    por <= 1'b0;
    #1;
    wt("np_run", PRKG, 1'b1, 10);
    @(posedge clk);
    fault <= 1'b1;
    #1;
    wt("fp_parked", PRK, 1'b1, FP + 10);
    chk("fp_len", n >= FP - 2, 1'b1);
    wt("oe_rel", OE, 1'b0, 10);
    $display("test fast park done");
  endtask
  task automatic t_off();
    @(posedge clk);
    fault <= 1'b0;
    pgood <= 1'b0;
    @(posedge clk);
    pgood <= 1'b1;
    #1;
    wt("oe2", OE, 1'b1, 100);
    // Early lock and early config done, config done must not skip the load
    @(posedge clk);
    pll_lk <= 1'b1;
    cfg_dn <= 1'b1;
    @(posedge clk);
    pll_lk <= 1'b0;
    #1;
    chk("lock_early", pick(CFG), 1'b1);
    chk("busy_early", pick(ST), 1'b1);
    @(posedge clk);
    cfg_dn <= 1'b0;
    #1;
    chk("done2", pick(ST), 1'b0);
    chk("off", pick(PRJ), 1'b0);
    @(posedge clk);
    por <= 1'b1;
    #1;
    wt("on", PRJ, 1'b1, 10);
    @(posedge clk);
    fault <= 1'b1;
    #1;
    wt("fp_on", PRKG, 1'b1, 10);
    wt("fp_on_end", PRK, 1'b1, FP + 10);
    $display("test off and fast park done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_init();
    t_npark();
    t_fpark();
    t_off();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
